// *** logic/dis_regs.svh ***
// register indices, field positions, reset values and timing counts
`ifndef DIS_REGS_SVH
`define DIS_REGS_SVH
// ----------------------------------------
// register indices, byte address = 4 * index
// ----------------------------------------
`define DIS_IDX_CTRL 4'h0
`define DIS_IDX_STAT 4'h1
`define DIS_IDX_UPD 4'h2
`define DIS_IDX_TCKE 4'h3
`define DIS_IDX_RESET_EXIT_WAIT 4'h4
`define DIS_IDX_MODE_WRITE_CYCLE_TIME 4'h5
`define DIS_IDX_MODE_UPDATE_DELAY 4'h6
`define DIS_IDX_TDLL 4'h7
`define DIS_IDX_TZQ 4'h8
`define DIS_IDX_MR0 4'h9
`define DIS_NREG 16
`define DIS_ADR_HI_ZERO 2'h0
// ----------------------------------------
// fields
// ----------------------------------------
`define DIS_CTRL_START 0
`define DIS_CTRL_RTT 1
`define DIS_CTRL_ODT 2
`define DIS_STAT_READY 0
`define DIS_STAT_BUSY 1
`define DIS_STAT_PEND 2
`define DIS_STAT_ST_LSB 8
`define DIS_TW 16
`define DIS_MRW 18
`define DIS_IDXW 3
// ----------------------------------------
// reset values of the wait registers
// ----------------------------------------
`define DIS_RESET_EXIT_WAIT_DEF 32'h0000_0010
`define DIS_MODE_WRITE_CYCLE_TIME_DEF 32'h0000_0008
`define DIS_MODE_UPDATE_DELAY_DEF 32'h0000_0018
`define DIS_TDLL_DEF 32'h0000_0300
`define DIS_TZQ_DEF 32'h0000_0400
// ----------------------------------------
// times and derived cycle counts
// ----------------------------------------
`define DIS_CLK_NS 50
`define DIS_T_RST_NS 100
`define DIS_T_CKSTB_NS 10
`define DIS_CKSTB_TCK 5
`define DIS_XPR_TCK 5
`define DIS_T_CKE_US 500
`define DIS_CEIL_CYC(ns) (((ns) + `DIS_CLK_NS - 1) / `DIS_CLK_NS)
`define DIS_RST_CYC `DIS_CEIL_CYC(`DIS_T_RST_NS)
`define DIS_CKSTB_CYC ((`DIS_CEIL_CYC(`DIS_T_CKSTB_NS) > `DIS_CKSTB_TCK) ? \
  `DIS_CEIL_CYC(`DIS_T_CKSTB_NS) : `DIS_CKSTB_TCK)
`define DIS_CKE_CYC `DIS_CEIL_CYC(`DIS_T_CKE_US * 1000)
// ----------------------------------------
// command pins {ras_n, cas_n, we_n}
// ----------------------------------------
`define DIS_CMD_MRS 3'h0
`define DIS_CMD_ZQ 3'h6
`define DIS_CMD_DES 3'h7
`define DIS_ZQ_LONG_BIT 10
`define DIS_LAST_STEP 3'h6
// mode register order, step 0 in the low bits: 3,6,5,4,2,1,0
`define DIS_MR_ORDER 21'o0124563
`endif

// *** logic/dis_pkg.sv ***
// types of the dram init sequencer
package dis_pkg;
  typedef enum logic [9:0] {
    DIS_ST_RST = 10'h001,
    DIS_ST_CKW = 10'h002,
    DIS_ST_XPR = 10'h004,
    DIS_ST_MRS = 10'h008,
    DIS_ST_MRD = 10'h010,
    DIS_ST_ZQ = 10'h020,
    DIS_ST_ZQW = 10'h040,
    DIS_ST_RDY = 10'h080,
    DIS_ST_UPD = 10'h100,
    DIS_ST_MODW = 10'h200
  } dis_state_t;
endpackage

// *** logic/dis_timer.sv ***
// down counter for the sequencer waits
`timescale 1ns/1ns
`include "dis_regs.svh"
module dis_timer #(
  parameter logic [15:0] INIT = 16'h0002
) (
  // system
  input wire logic clk_sys,
  input wire logic rstn,
  // control
  input wire logic load,
  input wire logic [`DIS_TW-1:0] load_val,
  output logic done
);
  logic [`DIS_TW-1:0] count_reg;
  logic [`DIS_TW-1:0] count_next;

  always_comb begin
    count_next = count_reg;
    if (load) begin
      count_next = load_val;
    end else if (count_reg != '0) begin
      count_next = count_reg - 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      count_reg <= INIT;
    end else begin
      count_reg <= count_next;
    end
  end

  assign done = (count_reg == '0);
endmodule

// *** logic/dis_wb_regs.sv ***
// wishbone classic slave with the sequencer registers
`timescale 1ns/1ns
`include "dis_regs.svh"
module dis_wb_regs #(
  parameter logic [15:0] CKE_CYC = 16'h2710
) (
  // system
  input wire logic clk_sys,
  input wire logic rstn,
  // wishbone
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // status in
  input wire logic [31:0] stat_word,
  // orders out
  output logic start_p,
  output logic upd_p,
  output logic [`DIS_IDXW-1:0] upd_idx,
  output logic rtt_en,
  output logic odt_lvl,
  output logic [`DIS_TW-1:0] t_cke,
  output logic [`DIS_TW-1:0] t_xpr,
  output logic [`DIS_TW-1:0] t_mrd,
  output logic [`DIS_TW-1:0] t_mod,
  output logic [`DIS_TW-1:0] t_dll,
  output logic [`DIS_TW-1:0] t_zq,
  output logic [`DIS_MRW-1:0] mr_val [7]
);
  logic [31:0] cfg_reg [`DIS_NREG];
  logic [31:0] cfg_next [`DIS_NREG];
  logic ack_reg, ack_next;
  logic [31:0] dat_reg, dat_next;
  logic start_reg, start_next;
  logic upd_reg, upd_next;
  logic hit, mapped;
  logic [3:0] idx;
  logic [31:0] wmask;

  assign hit = wb_cyc_i && wb_stb_i && !ack_reg;
  assign mapped = (wb_adr_i[7:6] == `DIS_ADR_HI_ZERO);
  assign idx = wb_adr_i[5:2];
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // ----------------------------------------
  // register entries
  // ----------------------------------------
  for (genvar i = 0; i < `DIS_NREG; i++) begin : g_reg
    localparam logic [31:0] RV =
      (i == `DIS_IDX_TCKE) ? {16'h0000, CKE_CYC} :
      (i == `DIS_IDX_RESET_EXIT_WAIT) ? `DIS_RESET_EXIT_WAIT_DEF :
      (i == `DIS_IDX_MODE_WRITE_CYCLE_TIME) ? `DIS_MODE_WRITE_CYCLE_TIME_DEF :
      (i == `DIS_IDX_MODE_UPDATE_DELAY) ? `DIS_MODE_UPDATE_DELAY_DEF :
      (i == `DIS_IDX_TDLL) ? `DIS_TDLL_DEF :
      (i == `DIS_IDX_TZQ) ? `DIS_TZQ_DEF : 32'h0000_0000;
    always_comb begin
      cfg_next[i] = cfg_reg[i];
      if (hit && wb_we_i && mapped && idx == 4'(i) && i != `DIS_IDX_STAT) begin
        cfg_next[i] = (cfg_reg[i] & ~wmask) | (wb_dat_i & wmask);
      end
      if (i == `DIS_IDX_CTRL) begin
        cfg_next[i][`DIS_CTRL_START] = 1'b0;
      end
    end
    always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
        cfg_reg[i] <= RV;
      end else begin
        cfg_reg[i] <= cfg_next[i];
      end
    end
  end

  // ----------------------------------------
  // bus answer and order pulses
  // ----------------------------------------
  always_comb begin
    ack_next = hit;
    dat_next = dat_reg;
    start_next = 1'b0;
    upd_next = 1'b0;
    if (hit) begin
      dat_next = 32'h0000_0000;
      if (!wb_we_i && mapped) begin
        dat_next = (idx == `DIS_IDX_STAT) ? stat_word : cfg_reg[idx];
      end
      if (wb_we_i && mapped && idx == `DIS_IDX_CTRL) begin
        start_next = wb_sel_i[0] && wb_dat_i[`DIS_CTRL_START];
      end
      if (wb_we_i && mapped && idx == `DIS_IDX_UPD) begin
        upd_next = wb_sel_i[0];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
      start_reg <= 1'b0;
      upd_reg <= 1'b0;
    end else begin
      ack_reg <= ack_next;
      dat_reg <= dat_next;
      start_reg <= start_next;
      upd_reg <= upd_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;
  assign start_p = start_reg;
  assign upd_p = upd_reg;
  assign upd_idx = cfg_reg[`DIS_IDX_UPD][`DIS_IDXW-1:0];
  assign rtt_en = cfg_reg[`DIS_IDX_CTRL][`DIS_CTRL_RTT];
  assign odt_lvl = cfg_reg[`DIS_IDX_CTRL][`DIS_CTRL_ODT];
  assign t_cke = cfg_reg[`DIS_IDX_TCKE][`DIS_TW-1:0];
  assign t_xpr = cfg_reg[`DIS_IDX_RESET_EXIT_WAIT][`DIS_TW-1:0];
  assign t_mrd = cfg_reg[`DIS_IDX_MODE_WRITE_CYCLE_TIME][`DIS_TW-1:0];
  assign t_mod = cfg_reg[`DIS_IDX_MODE_UPDATE_DELAY][`DIS_TW-1:0];
  assign t_dll = cfg_reg[`DIS_IDX_TDLL][`DIS_TW-1:0];
  assign t_zq = cfg_reg[`DIS_IDX_TZQ][`DIS_TW-1:0];
  for (genvar m = 0; m < 7; m++) begin : g_mr
    assign mr_val[m] = cfg_reg[`DIS_IDX_MR0 + m][`DIS_MRW-1:0];
  end
endmodule

// *** logic/dis_init_ctrl.sv ***
// dram reset, init and mode register sequencer (controller side)
`timescale 1ns/1ns
`include "dis_regs.svh"
module dis_init_ctrl #(
  parameter int CKE_CYC = `DIS_CKE_CYC
) (
  // system
  input wire logic clk_sys,
  input wire logic rstn,
  // wishbone
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // scheduler
  input wire logic dram_idle,
  output logic init_done,
  // dram pins
  output logic dram_ck_en,
  output logic dram_reset_n,
  output logic dram_cke,
  output logic dram_odt,
  output logic dram_ten,
  output logic dram_cs_n,
  output logic dram_ras_n,
  output logic dram_cas_n,
  output logic dram_we_n,
  output logic [1:0] dram_bg,
  output logic [1:0] dram_ba,
  output logic [`DIS_MRW-1:0] dram_addr
);
  localparam logic [15:0] CKSTB = 16'(`DIS_CKSTB_CYC);
  localparam logic [15:0] XPRMIN = 16'(`DIS_XPR_TCK);

  dis_pkg::dis_state_t state_reg, state_next;
  logic [2:0] step_reg, step_next;
  logic rst_n_reg, rst_n_next;
  logic cke_reg, cke_next;
  logic odt_reg, odt_next;
  logic cken_reg, cken_next;
  logic cs_n_reg, cs_n_next;
  logic [2:0] cmd_reg, cmd_next;
  logic [2:0] sel_reg, sel_next;
  logic [`DIS_MRW-1:0] addr_reg, addr_next;
  logic rdy_reg, rdy_next;
  logic pend_reg, pend_next;
  logic [2:0] pidx_reg, pidx_next;
  logic tload, tdone;
  logic [`DIS_TW-1:0] tval;
  logic start_p, upd_p, rtt_en, odt_lvl;
  logic [2:0] upd_idx, mr_sel;
  logic [`DIS_TW-1:0] t_cke, t_xpr, t_mrd, t_mod, t_dll, t_zq;
  logic [`DIS_MRW-1:0] mr_val [7];
  logic [31:0] stat_word;
  logic [20:0] mr_order;

  function automatic logic [15:0] dis_max(input logic [15:0] a, input logic [15:0] b);
    dis_max = (a > b) ? a : b;
  endfunction

  // ----------------------------------------
  // register file and wait timer
  // ----------------------------------------
  dis_wb_regs #(.CKE_CYC(16'(CKE_CYC))) u_regs (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .stat_word(stat_word),
    .start_p(start_p),
    .upd_p(upd_p),
    .upd_idx(upd_idx),
    .rtt_en(rtt_en),
    .odt_lvl(odt_lvl),
    .t_cke(t_cke),
    .t_xpr(t_xpr),
    .t_mrd(t_mrd),
    .t_mod(t_mod),
    .t_dll(t_dll),
    .t_zq(t_zq),
    .mr_val(mr_val)
  );

  dis_timer #(.INIT(16'(`DIS_RST_CYC))) u_timer (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .load(tload),
    .load_val(tval),
    .done(tdone)
  );

  assign stat_word = {14'h0000, state_reg, 5'h00, pend_reg, !rdy_reg, rdy_reg};
  assign mr_order = `DIS_MR_ORDER;
  assign mr_sel = mr_order[3 * step_reg +: 3];

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    step_next = step_reg;
    rst_n_next = rst_n_reg;
    cke_next = cke_reg;
    odt_next = odt_reg;
    cken_next = cken_reg;
    cs_n_next = 1'b1;
    cmd_next = `DIS_CMD_DES;
    sel_next = sel_reg;
    addr_next = addr_reg;
    rdy_next = rdy_reg;
    pend_next = pend_reg || upd_p;
    pidx_next = upd_p ? upd_idx : pidx_reg;
    tload = 1'b0;
    tval = '0;
    unique case (state_reg)
      dis_pkg::DIS_ST_RST: begin
        if (tdone) begin
          rst_n_next = 1'b1;
          cken_next = 1'b1;
          odt_next = odt_lvl && !rtt_en;
          tload = 1'b1;
          tval = dis_max(t_cke, CKSTB);
          state_next = dis_pkg::DIS_ST_CKW;
        end
      end
      dis_pkg::DIS_ST_CKW: begin
        if (tdone) begin
          cke_next = 1'b1;
          tload = 1'b1;
          tval = dis_max(t_xpr, XPRMIN);
          state_next = dis_pkg::DIS_ST_XPR;
        end
      end
      dis_pkg::DIS_ST_XPR: begin
        if (tdone) begin
          state_next = dis_pkg::DIS_ST_MRS;
        end
      end
      dis_pkg::DIS_ST_MRS: begin
        cs_n_next = 1'b0;
        cmd_next = `DIS_CMD_MRS;
        sel_next = mr_sel;
        addr_next = mr_val[mr_sel];
        tload = 1'b1;
        tval = (step_reg == `DIS_LAST_STEP) ? dis_max(t_mrd, t_mod) : t_mrd;
        state_next = dis_pkg::DIS_ST_MRD;
      end
      dis_pkg::DIS_ST_MRD: begin
        if (tdone) begin
          if (step_reg == `DIS_LAST_STEP) begin
            state_next = dis_pkg::DIS_ST_ZQ;
          end else begin
            step_next = step_reg + 3'h1;
            state_next = dis_pkg::DIS_ST_MRS;
          end
        end
      end
      dis_pkg::DIS_ST_ZQ: begin
        cs_n_next = 1'b0;
        cmd_next = `DIS_CMD_ZQ;
        addr_next = '0;
        addr_next[`DIS_ZQ_LONG_BIT] = 1'b1;
        tload = 1'b1;
        tval = dis_max(t_dll, t_zq);
        state_next = dis_pkg::DIS_ST_ZQW;
      end
      dis_pkg::DIS_ST_ZQW: begin
        if (tdone) begin
          rdy_next = 1'b1;
          state_next = dis_pkg::DIS_ST_RDY;
        end
      end
      dis_pkg::DIS_ST_RDY: begin
        odt_next = odt_lvl;
        if (pend_reg && dram_idle) begin
          odt_next = odt_lvl && !rtt_en;
          state_next = dis_pkg::DIS_ST_UPD;
        end
      end
      dis_pkg::DIS_ST_UPD: begin
        if (dram_idle && cke_reg) begin
          cs_n_next = 1'b0;
          cmd_next = `DIS_CMD_MRS;
          sel_next = pidx_reg;
          addr_next = mr_val[pidx_reg];
          pend_next = upd_p;
          tload = 1'b1;
          tval = dis_max(t_mrd, t_mod);
          state_next = dis_pkg::DIS_ST_MODW;
        end else begin
          state_next = dis_pkg::DIS_ST_RDY;
        end
      end
      dis_pkg::DIS_ST_MODW: begin
        if (tdone) begin
          state_next = dis_pkg::DIS_ST_RDY;
        end
      end
    endcase
    if (start_p) begin
      rst_n_next = 1'b0;
      cke_next = 1'b0;
      cken_next = 1'b0;
      cs_n_next = 1'b1;
      cmd_next = `DIS_CMD_DES;
      rdy_next = 1'b0;
      step_next = 3'h0;
      tload = 1'b1;
      tval = 16'(`DIS_RST_CYC);
      state_next = dis_pkg::DIS_ST_RST;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_reg <= dis_pkg::DIS_ST_RST;
      step_reg <= 3'h0;
      rst_n_reg <= 1'b0;
      cke_reg <= 1'b0;
      odt_reg <= 1'b0;
      cken_reg <= 1'b0;
      cs_n_reg <= 1'b1;
      cmd_reg <= `DIS_CMD_DES;
      sel_reg <= 3'h0;
      addr_reg <= '0;
      rdy_reg <= 1'b0;
      pend_reg <= 1'b0;
      pidx_reg <= 3'h0;
    end else begin
      state_reg <= state_next;
      step_reg <= step_next;
      rst_n_reg <= rst_n_next;
      cke_reg <= cke_next;
      odt_reg <= odt_next;
      cken_reg <= cken_next;
      cs_n_reg <= cs_n_next;
      cmd_reg <= cmd_next;
      sel_reg <= sel_next;
      addr_reg <= addr_next;
      rdy_reg <= rdy_next;
      pend_reg <= pend_next;
      pidx_reg <= pidx_next;
    end
  end

  assign init_done = rdy_reg;
  assign dram_ck_en = cken_reg;
  assign dram_reset_n = rst_n_reg;
  assign dram_cke = cke_reg;
  assign dram_odt = odt_reg;
  assign dram_ten = 1'b0;
  assign dram_cs_n = cs_n_reg;
  assign {dram_ras_n, dram_cas_n, dram_we_n} = cmd_reg;
  assign dram_bg = {1'b0, sel_reg[2]};
  assign dram_ba = sel_reg[1:0];
  assign dram_addr = addr_reg;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  logic [15:0] rel_cnt, cke_cnt, gap_cnt, zq_cnt;
  logic [15:0] rel_nx, cke_nx, gap_nx, zq_nx;
  logic [6:0] seen_reg, seen_nx;
  logic is_mrs, is_zq;

  assign is_mrs = !dram_cs_n && {dram_ras_n, dram_cas_n, dram_we_n} == `DIS_CMD_MRS;
  assign is_zq = !dram_cs_n && {dram_ras_n, dram_cas_n, dram_we_n} == `DIS_CMD_ZQ;

  function automatic logic [15:0] sat(input logic [15:0] c);
    sat = (c == 16'hffff) ? c : c + 16'h0001;
  endfunction

  always_comb begin
    rel_nx = dram_reset_n ? sat(rel_cnt) : 16'h0000;
    cke_nx = dram_cke ? sat(cke_cnt) : 16'h0000;
    gap_nx = is_mrs ? 16'h0000 : sat(gap_cnt);
    zq_nx = is_zq ? 16'h0000 : sat(zq_cnt);
    seen_nx = seen_reg;
    if (is_mrs) begin
      seen_nx[{dram_bg[0], dram_ba}] = 1'b1;
    end
    if (!dram_reset_n) begin
      seen_nx = 7'h00;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rel_cnt <= 16'h0000;
      cke_cnt <= 16'h0000;
      gap_cnt <= 16'hffff;
      zq_cnt <= 16'h0000;
      seen_reg <= 7'h00;
    end else begin
      rel_cnt <= rel_nx;
      cke_cnt <= cke_nx;
      gap_cnt <= gap_nx;
      zq_cnt <= zq_nx;
      seen_reg <= seen_nx;
    end
  end

  sequence s_rel;
    $rose(dram_reset_n);
  endsequence
  sequence s_init_mrs;
    is_mrs && !init_done;
  endsequence

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  rst_hold_a: assert property (s_rel |-> $past(dram_reset_n, 2) == 1'b0)
    else $error("reset pulse shorter than minimum");
  cke_rel_a: assert property (s_rel |-> !dram_cke && $past(dram_cke) == 1'b0)
    else $error("clock enable not low before reset release");
  cke_wait_a: assert property ($rose(dram_cke) |-> rel_cnt >= t_cke && rel_cnt >= CKSTB)
    else $error("clock enable raised too early");
  ck_run_a: assert property ($rose(dram_cke) |-> $past(dram_ck_en, 5))
    else $error("clock not running before clock enable");
  cke_keep_a: assert property (dram_cke && !start_p |=> dram_cke)
    else $error("clock enable dropped");
  odt_static_a: assert property (dram_cke && !init_done && !start_p |=> $stable(dram_odt))
    else $error("termination input changed during init");
  xpr_wait_a: assert property (s_init_mrs and seen_reg == 7'h00 |-> cke_cnt >= t_xpr)
    else $error("first mode write before reset exit wait");
  first_mr_a: assert property (s_init_mrs and seen_reg == 7'h00 |-> dram_ba == 2'h3)
    else $error("init does not start with register three");
  des_gap_a: assert property (s_init_mrs |=> dram_cs_n)
    else $error("no deselect after mode write");
  dll_order_a: assert property (s_init_mrs and {dram_bg[0], dram_ba} == 3'h0
    |-> seen_reg[1])
    else $error("register zero before register one");
  mrd_gap_a: assert property (is_mrs && seen_reg != 7'h00 |-> gap_cnt >= t_mrd)
    else $error("mode writes too close");
  mod_gap_a: assert property (is_zq |-> gap_cnt >= t_mod)
    else $error("command too soon after mode write");
  ready_wait_a: assert property ($rose(init_done) |-> zq_cnt >= t_dll && zq_cnt >= t_zq
    && seen_reg == 7'h7f)
    else $error("ready before all waits or writes");
  upd_idle_a: assert property (is_mrs && init_done |-> $past(dram_idle) && dram_cke)
    else $error("runtime mode write while busy");
  upd_odt_a: assert property (rtt_en && (is_mrs && init_done
    || state_reg == dis_pkg::DIS_ST_MODW) |-> !dram_odt)
    else $error("termination high around mode write");
endmodule

// *** verif/dis_dram_model.sv ***
// dram device model seen from its pins
`timescale 1ns/1ns
`include "dis_regs.svh"
module dis_dram_model (
  // clock and control
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic cke,
  // command and address
  input wire logic cs_n,
  input wire logic [2:0] cmd,
  input wire logic [2:0] idx,
  input wire logic [`DIS_MRW-1:0] addr,
  // observation
  output logic mrs_seen,
  output logic [2:0] last_idx,
  output logic [`DIS_MRW-1:0] last_val,
  output logic term_hiz
);
  logic cke_taken;
  assign term_hiz = !reset_n || !cke_taken;
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cke_taken <= 1'b0;
      mrs_seen <= 1'b0;
    end else begin
      cke_taken <= cke_taken || cke;
      mrs_seen <= cke && !cs_n && cmd == `DIS_CMD_MRS;
      if (cke && !cs_n && cmd == `DIS_CMD_MRS) begin
        last_idx <= idx;
        last_val <= addr;
      end
    end
  end
endmodule

// *** verif/tb.sv ***
// self-checking bench for the dram init sequencer
`timescale 1ns/1ns
`include "dis_regs.svh"
module tb;
  localparam int CKE_CYC = 20;
  localparam logic [2:0] ORD [7] = '{3'h3, 3'h6, 3'h5, 3'h4, 3'h2, 3'h1, 3'h0};
  logic clk_sys = 1'b0;
  logic rstn = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, dram_idle = 1'b1;
  logic [7:0] wb_adr_i = 8'h0;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic wb_ack_o, init_done, dram_ck_en, dram_reset_n, dram_cke, dram_odt, dram_ten;
  logic dram_cs_n, dram_ras_n, dram_cas_n, dram_we_n, mrs_seen, term_hiz;
  logic [1:0] dram_bg, dram_ba;
  logic [2:0] last_idx;
  logic [`DIS_MRW-1:0] dram_addr, last_val;
  logic [`DIS_MRW-1:0] mrv [7];
  logic [20:0] exp_q[$];
  logic [31:0] rd_q[$];
  int num_errors = 0, tests_run = 0, seed = 68, cyc = 0;
  int t_xpr = `DIS_RESET_EXIT_WAIT_DEF, t_mrd = `DIS_MODE_WRITE_CYCLE_TIME_DEF, t_mod = `DIS_MODE_UPDATE_DELAY_DEF;
  int t_dll = `DIS_TDLL_DEF, t_zq = `DIS_TZQ_DEF;
  int s_rst = 0, s_low = 0, s_cke = 0, s_mrs = 0, s_zq = 0, n_mrs = 0, ck_run = 0;
  bit armed = 0, rtt_on = 0, restarting = 0, hold_off = 0;
  logic p_cke = 1'b0, p_odt = 1'b0, p_done = 1'b0;
  always #25 clk_sys = ~clk_sys;
  dis_init_ctrl #(.CKE_CYC(CKE_CYC)) DUT (.clk_sys, .rstn, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .dram_idle, .init_done,
    .dram_ck_en, .dram_reset_n, .dram_cke, .dram_odt, .dram_ten, .dram_cs_n, .dram_ras_n,
    .dram_cas_n, .dram_we_n, .dram_bg, .dram_ba, .dram_addr);
  dis_dram_model mem (.clk_sys, .reset_n(dram_reset_n), .cke(dram_cke), .cs_n(dram_cs_n),
    .cmd({dram_ras_n, dram_cas_n, dram_we_n}), .idx({dram_bg[0], dram_ba}),
    .addr(dram_addr), .mrs_seen, .last_idx, .last_val, .term_hiz);
  // ----------------------------------------
  // checking and bus tasks
  // ----------------------------------------
  task automatic finish_test();
    if (num_errors == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    do begin
      @(posedge clk_sys);
    end while (wb_ack_o !== 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    wb(1'b0, a, 32'h0);
  endtask
  task automatic wait_for(input logic lvl);
    int n;
    n = 0;
    while (init_done !== lvl && n < 9000) begin
      @(posedge clk_sys);
      n++;
    end
    chk(init_done === lvl, "ready wait");
  endtask
  // ----------------------------------------
  // pin monitor and scoreboard
  // ----------------------------------------
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc > 20000) begin
      num_errors++;
      finish_test();
    end
    if (dram_reset_n === 1'b1 && s_rst == 0) chk(s_low >= 2, "reset pulse");
    s_low = dram_reset_n ? 0 : s_low + 1;
    s_rst = dram_reset_n ? s_rst + 1 : 0;
    ck_run = dram_ck_en ? ck_run + 1 : 0;
    s_cke = dram_cke ? s_cke + 1 : 0;
    s_mrs++;
    s_zq++;
    if (dram_reset_n !== 1'b1) begin
      n_mrs = 0;
      s_mrs = 1000;
      chk(dram_cke === 1'b0, "cke in reset");
    end
    chk(dram_ten === 1'b0, "scan enable");
    if (init_done === 1'b1) chk(term_hiz === 1'b0, "termination off");
    if (dram_cke === 1'b1 && !p_cke) chk(s_rst >= CKE_CYC && ck_run >= 5, "cke early");
    chk(restarting || p_done || !p_cke || dram_cke === 1'b1, "cke dropped");
    if (p_cke && dram_cke === 1'b1 && init_done === 1'b0)
      chk(dram_odt === p_odt && !(rtt_on && dram_odt), "odt moved");
    if (dram_cs_n === 1'b0 && init_done === 1'b0)
      chk({dram_ras_n, dram_cas_n, dram_we_n} inside {`DIS_CMD_MRS, `DIS_CMD_ZQ}, "cmd");
    if (dram_cs_n === 1'b0 && {dram_ras_n, dram_cas_n, dram_we_n} === `DIS_CMD_MRS) begin
      chk(s_mrs >= t_mrd && dram_cke === 1'b1 && !hold_off, "mode write");
      if (n_mrs == 0) chk(s_cke >= t_xpr && s_cke >= 5, "exit wait");
      n_mrs++;
      s_mrs = 0;
    end
    if (dram_cs_n === 1'b0 && {dram_ras_n, dram_cas_n, dram_we_n} === `DIS_CMD_ZQ) begin
      chk(dram_addr[`DIS_ZQ_LONG_BIT] === 1'b1 && n_mrs == 7 && s_mrs >= t_mod, "zq");
      s_zq = 0;
    end
    if (init_done === 1'b1 && !p_done) chk(s_zq >= t_dll && s_zq >= t_zq, "early");
    if (rtt_on) chk(s_mrs >= t_mod || dram_odt === 1'b0, "odt in update");
    if (mrs_seen === 1'b1 && armed)
      chk(exp_q.size() > 0 && {last_idx, last_val} === exp_q.pop_front(), "mr");
    if (wb_ack_o === 1'b1 && !wb_we_i && rd_q.size() > 0)
      chk(wb_dat_o === rd_q.pop_front(), "read data");
    p_cke = dram_cke;
    p_odt = dram_odt;
    p_done = init_done;
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [`DIS_MRW-1:0] v;
    int i, n;
    rstn <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b1;
    rd(8'h0c, CKE_CYC);
    rd(8'h10, `DIS_RESET_EXIT_WAIT_DEF);
    rd(8'h14, `DIS_MODE_WRITE_CYCLE_TIME_DEF);
    rd(8'h18, `DIS_MODE_UPDATE_DELAY_DEF);
    rd(8'h1c, `DIS_TDLL_DEF);
    rd(8'h20, `DIS_TZQ_DEF);
    wb(1'b1, 8'h44, 32'hffff_ffff);
    rd(8'h44, 32'h0);
    wait_for(1'b1);
    rd(8'h04, 32'h0000_8001);
    t_dll = 32'h28;
    t_zq = 32'h30;
    wb(1'b1, 8'h1c, 32'h28);
    wb(1'b1, 8'h20, 32'h30);
    for (int k = 0; k < 7; k++) begin
      mrv[k] = `DIS_MRW'($random(seed));
      wb(1'b1, 8'h24 + 8'(4 * k), 32'(mrv[k]));
    end
    rd(8'h30, 32'(mrv[3]));
    foreach (ORD[k]) exp_q.push_back({ORD[k], mrv[ORD[k]]});
    armed = 1;
    restarting = 1;
    wb(1'b1, 8'h00, 32'h5);
    wait_for(1'b0);
    wait_for(1'b1);
    restarting = 0;
    chk(exp_q.size() == 0, "writes missing");
    rtt_on = 1;
    wb(1'b1, 8'h00, 32'h6);
    for (int k = 0; k < 4; k++) begin
      i = k == 0 ? 2 : $unsigned($random(seed)) % 7;
      v = `DIS_MRW'($random(seed));
      dram_idle <= (k != 0);
      hold_off = (k == 0);
      wb(1'b1, 8'h24 + 8'(4 * i), 32'(v));
      exp_q.push_back({3'(i), v});
      wb(1'b1, 8'h08, 32'(i));
      repeat (30) @(posedge clk_sys);
      hold_off = 0;
      dram_idle <= 1'b1;
      n = 0;
      while (exp_q.size() > 0 && n < 200) begin
        @(posedge clk_sys);
        n++;
      end
      chk(exp_q.size() == 0, "update lost");
    end
    finish_test();
  end
endmodule
